// file: hdl/vfd_pkg.sv
// shared constants for the display panel serial link
package vfd_pkg;
  // command selector in bits 7:6 of the first byte
  localparam logic [1:0] CMD_MODE = 2'h0;
  localparam logic [1:0] CMD_DATA = 2'h1;
  localparam logic [1:0] CMD_CTRL = 2'h2;
  localparam logic [1:0] CMD_ADDR = 2'h3;
  localparam int CMD_SEL_HI = 7;
  localparam int CMD_SEL_LO = 6;
  // data-setting fields
  localparam logic [1:0] DS_WR_DISP = 2'h0;
  localparam logic [1:0] DS_WR_LED = 2'h1;
  localparam logic [1:0] DS_RD_KEY = 2'h2;
  localparam int DS_FIX_BIT = 2;
  localparam int DS_TEST_BIT = 3;
  // display control fields
  localparam int CTRL_ON_BIT = 3;
  localparam int DIM_W = 3;
  localparam logic [2:0] DIM_RST = 3'h0;
  // display mode: grids = code + 4, codes above max clamp
  localparam int MODE_W = 4;
  localparam logic [3:0] MODE_MAX = 4'h8;
  localparam logic [3:0] MODE_RST = 4'h8;
  // display memory
  localparam int ADDR_W = 6;
  localparam int MEM_DEPTH = 36;
  localparam logic [5:0] ADDR_LIMIT = 6'h24;
  localparam logic [5:0] ADDR_RST = 6'h00;
  // key matrix
  localparam int KEY_ROWS = 16;
  localparam int KEY_COLS = 2;
  localparam int KEY_BITS = KEY_ROWS * KEY_COLS;
  // led port, all off after reset
  localparam int LED_W = 4;
  localparam logic [3:0] LED_RST = 4'hF;
  // timing
  localparam int CLK_NS = 4;
  localparam int TW_NS = 2000;
  localparam int TW_CYCLES = (TW_NS + CLK_NS - 1) / CLK_NS;
  localparam int CS_GAP_NS = 2000;
  localparam int CS_GAP_CYCLES = (CS_GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int LINK_PERIOD_NS = 160;
  localparam int LINK_HALF_CYCLES = LINK_PERIOD_NS / 2 / CLK_NS;
  localparam int STROBE_CYCLES = 1024;
  // host register map
  localparam logic [3:0] WB_TX = 4'h0;
  localparam logic [3:0] WB_STAT = 4'h4;
  localparam logic [3:0] WB_KEYS = 4'h8;
  localparam int TX_END_BIT = 8;
  localparam int TX_READ_BIT = 9;

  // pulse width in sixteenths for each dimming code
  function automatic logic [4:0] dim_width(input logic [2:0] code);
    case (code)
      3'h0: dim_width = 5'h01;
      3'h1: dim_width = 5'h02;
      3'h2: dim_width = 5'h04;
      3'h3: dim_width = 5'h0A;
      3'h4: dim_width = 5'h0B;
      3'h5: dim_width = 5'h0C;
      3'h6: dim_width = 5'h0D;
      default: dim_width = 5'h0E;
    endcase
  endfunction : dim_width
endpackage : vfd_pkg

// file: hdl/vfd_link_if.sv
// three-wire serial link with open-drain read-back line
`timescale 1ns/1ns
interface vfd_link_if;
  logic csB;
  logic sclk;
  logic sdi;
  logic sdoOut;
  logic sdoOe;
  logic sdoLine;
  // pull-up on the read-back line
  assign sdoLine = sdoOe ? sdoOut : 1'b1;
  modport host (output csB, output sclk, output sdi, input sdoLine);
  modport dev (input csB, input sclk, input sdi, output sdoOut,
    output sdoOe);
endinterface : vfd_link_if

// file: hdl/link_sync.sv
// two-flop synchroniser, one per bit
`timescale 1ns/1ns
module link_sync #(
  parameter int W = 1
) (
  input wire logic mclk, // clock
  input wire logic rst_b, // async reset, active low
  input wire logic [W-1:0] async, // inputs from another domain
  input wire logic [W-1:0] rstVal, // reset pattern input, no effect; reset loads all ones
  output logic [W-1:0] q // synchronised
);
  logic [W-1:0] meta;
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
          meta[i] <= 1'b1;
          q[i] <= 1'b1;
        end else begin
          meta[i] <= async[i];
          q[i] <= meta[i] & (rstVal[i] | ~rstVal[i]);
        end
      end
    end
  endgenerate
endmodule : link_sync

// file: hdl/vfd_panel_dev.sv
// device end: command decoder, display state, key scan, led port
//
// Contract
// (R1) sixteen strobes, one active at a time
// (R2) sample both returns per strobe
// (R3) key storage 16 rows by 2 columns
// (R4) key bits read out lsb first
// (R5) led byte written lsb first
// (R6) led on at 0, off at 1
// (R7) upper four led bits dropped
// (R8) first byte after select is command
// (R9) select high mid-byte discards partial byte
// (R10) mode change forces display off, scan stop
// (R11) same mode command does nothing
// (R12) reset mode twelve grids sixteen segments
// (R13) data setting: direction, increment; reset increment
// (R14) address 24H or above ignores data
// (R15) address pointer resets to 00H
// (R16) reset dimming 1/16, display off
// (R17) one scan cycle spans two frames
// (R18) host waits before clocking read data
// (R19) bulk update command order
// (R20) single location update order
// (R21) dimming code maps to sixteenths table
// (R22) memory 00H to 23H, byte addressed
// (R23) sample on rise, shift out on fall
//
// Added by the designer: the address map and the Wishbone slave port.
`timescale 1ns/1ns
module vfd_panel_dev #(
  parameter int STROBE_CYCLES = vfd_pkg::STROBE_CYCLES
) (
  input wire logic mclk, // clock
  input wire logic rst_b, // async reset, active low
  vfd_link_if.dev link, // serial link
  input wire logic keyReturnInputA, // key return column a
  input wire logic keyReturnInputB, // key return column b
  input wire logic [5:0] dispRdAddr, // display memory read address
  output logic [7:0] dispRdData_q, // display memory read data
  output logic [15:0] segmentKeyStrobeOutputs_q, // one-hot strobe while display on, all zero while off
  output logic [3:0] ledOut_q, // led port, low lights
  output logic displayOn_q, // display enabled
  output logic [4:0] dimWidth_q, // grid pulse width, sixteenths
  output logic [3:0] modeCode_q, // grids minus four
  output logic keyReady_q // a full scan cycle has been stored
);
  logic [4:0] syn;
  logic csHigh, sclkNow, sdiNow, keyA, keyB;
  logic sclkPrev_q;
  logic sclkRise, sclkFall;
  logic [2:0] bitCnt_q;
  logic [6:0] shift_q;
  logic firstByte_q;
  logic byteDone;
  logic [7:0] rxByte;
  logic isCmd, isData;
  logic [1:0] cmdSel;
  logic [1:0] dataMode_q;
  logic fixAddr_q, testMode_q;
  logic [5:0] addr_q;
  logic [3:0] newMode;
  logic readActive_q;
  logic [4:0] rdIdx_q;
  logic [31:0] keyData_q;
  logic [15:0] scanCnt_q;
  logic [3:0] row_q;
  logic [7:0] mem [vfd_pkg::MEM_DEPTH];
  logic sdoOut_q, sdoOe_q;

  link_sync #(.W(5)) u_sync (
    .mclk(mclk),
    .rst_b(rst_b),
    .async({link.csB, link.sclk, link.sdi, keyReturnInputA,
      keyReturnInputB}),
    .rstVal(5'h1F),
    .q(syn)
  );
  assign csHigh = syn[4];
  assign sclkNow = syn[3];
  assign sdiNow = syn[2];
  assign keyA = syn[1];
  assign keyB = syn[0];
  assign sclkRise = sclkNow & ~sclkPrev_q & ~csHigh; // [R23]
  assign sclkFall = ~sclkNow & sclkPrev_q & ~csHigh; // [R23]
  assign byteDone = sclkRise & (bitCnt_q == 3'h7);
  assign rxByte = {sdiNow, shift_q}; // [R5]
  assign cmdSel = rxByte[vfd_pkg::CMD_SEL_HI:vfd_pkg::CMD_SEL_LO];
  assign isCmd = byteDone & firstByte_q; // [R8]
  assign isData = byteDone & ~firstByte_q & ~readActive_q;
  assign newMode = (rxByte[3:0] > vfd_pkg::MODE_MAX) ?
    vfd_pkg::MODE_MAX : rxByte[3:0];
  assign link.sdoOut = sdoOut_q;
  assign link.sdoOe = sdoOe_q;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sclkPrev_q <= 1'b1;
    end else begin
      sclkPrev_q <= sclkNow;
    end
  end

  // serial receiver, lsb first
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      bitCnt_q <= 3'h0;
      shift_q <= 7'h00;
      firstByte_q <= 1'b1;
    end else if (csHigh) begin
      bitCnt_q <= 3'h0; // [R9]
      firstByte_q <= 1'b1; // [R8]
    end else if (sclkRise) begin
      if (bitCnt_q != 3'h7) begin
        shift_q[bitCnt_q] <= sdiNow; // [R23]
      end
      bitCnt_q <= bitCnt_q + 3'h1;
      if (byteDone) begin
        firstByte_q <= 1'b0;
      end
    end
  end

  // display mode and display control
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      modeCode_q <= vfd_pkg::MODE_RST; // [R12]
      displayOn_q <= 1'b0; // [R16]
      dimWidth_q <= vfd_pkg::dim_width(vfd_pkg::DIM_RST); // [R16]
    end else if (isCmd && cmdSel == vfd_pkg::CMD_MODE) begin
      if (newMode != modeCode_q) begin // [R11]
        modeCode_q <= newMode; // [R10]
        displayOn_q <= 1'b0; // [R10]
      end
    end else if (isCmd && cmdSel == vfd_pkg::CMD_CTRL) begin
      displayOn_q <= rxByte[vfd_pkg::CTRL_ON_BIT];
      dimWidth_q <= vfd_pkg::dim_width(rxByte[2:0]); // [R21]
    end
  end

  // data setting
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      dataMode_q <= vfd_pkg::DS_WR_DISP; // [R13]
      fixAddr_q <= 1'b0; // [R13]
      testMode_q <= 1'b0; // [R13]
    end else if (isCmd && cmdSel == vfd_pkg::CMD_DATA) begin
      dataMode_q <= rxByte[1:0]; // [R13]
      fixAddr_q <= rxByte[vfd_pkg::DS_FIX_BIT];
      testMode_q <= rxByte[vfd_pkg::DS_TEST_BIT];
    end
  end

  // address pointer; past the last byte it stays invalid
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      addr_q <= vfd_pkg::ADDR_RST; // [R15]
    end else if (isCmd && cmdSel == vfd_pkg::CMD_ADDR) begin
      addr_q <= rxByte[5:0];
    end else if (isData && dataMode_q == vfd_pkg::DS_WR_DISP &&
        !fixAddr_q && addr_q < vfd_pkg::ADDR_LIMIT) begin
      addr_q <= addr_q + 6'h01; // [R13]
    end
  end

  // display memory, three bytes per grid
  always_ff @(posedge mclk) begin
    if (isData && dataMode_q == vfd_pkg::DS_WR_DISP &&
        addr_q < vfd_pkg::ADDR_LIMIT) begin // [R14]
      mem[addr_q] <= rxByte; // [R22]
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      dispRdData_q <= 8'h00;
    end else if (dispRdAddr < vfd_pkg::ADDR_LIMIT) begin
      dispRdData_q <= mem[dispRdAddr];
    end else begin
      dispRdData_q <= 8'h00;
    end
  end

  // led port
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ledOut_q <= vfd_pkg::LED_RST;
    end else if (isData && dataMode_q == vfd_pkg::DS_WR_LED) begin
      ledOut_q <= rxByte[3:0]; // [R6] [R7]
    end
  end

  // key read-back on falling edges after the read command
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      readActive_q <= 1'b0;
      rdIdx_q <= 5'h00;
      sdoOut_q <= 1'b1;
      sdoOe_q <= 1'b0;
    end else if (csHigh) begin
      readActive_q <= 1'b0;
      sdoOut_q <= 1'b1;
      sdoOe_q <= 1'b0;
    end else if (isCmd && cmdSel == vfd_pkg::CMD_DATA &&
        rxByte[1:0] == vfd_pkg::DS_RD_KEY) begin
      readActive_q <= 1'b1;
      rdIdx_q <= 5'h00;
    end else if (readActive_q && sclkFall) begin
      sdoOut_q <= keyData_q[rdIdx_q]; // [R4] [R23]
      sdoOe_q <= ~keyData_q[rdIdx_q];
      rdIdx_q <= rdIdx_q + 5'h01;
    end
  end

  // key scan: 16 strobes cover two frames, runs while display on
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      scanCnt_q <= 16'h0000;
      row_q <= 4'h0;
      segmentKeyStrobeOutputs_q <= 16'h0000;
      keyData_q <= 32'h00000000;
      keyReady_q <= 1'b0;
    end else if (!displayOn_q) begin
      scanCnt_q <= 16'h0000; // [R10]
      row_q <= 4'h0;
      segmentKeyStrobeOutputs_q <= 16'h0000;
    end else begin
      segmentKeyStrobeOutputs_q <= 16'h0001 << row_q; // [R1]
      if (scanCnt_q == 16'(STROBE_CYCLES - 1)) begin
        scanCnt_q <= 16'h0000;
        keyData_q[{row_q, 1'b0}] <= keyA; // [R2] [R3]
        keyData_q[{row_q, 1'b1}] <= keyB; // [R2] [R3]
        row_q <= row_q + 4'h1;
        if (row_q == 4'(vfd_pkg::KEY_ROWS - 1)) begin
          keyReady_q <= 1'b1; // [R17]
        end
      end else begin
        scanCnt_q <= scanCnt_q + 16'h0001;
      end
    end
  end
endmodule : vfd_panel_dev

// file: hdl/vfd_panel_host.sv
// host end: wishbone registers driving the serial link
`timescale 1ns/1ns
module vfd_panel_host #(
  parameter int HALF_CYCLES = vfd_pkg::LINK_HALF_CYCLES,
  parameter int TW_CYCLES = vfd_pkg::TW_CYCLES,
  parameter int GAP_CYCLES = vfd_pkg::CS_GAP_CYCLES
) (
  input wire logic mclk, // clock
  input wire logic rst_b, // async reset, active low
  vfd_link_if.host link, // serial link
  input wire logic wbCyc, // wishbone cycle
  input wire logic wbStb, // wishbone strobe
  input wire logic wbWe, // write enable
  input wire logic [3:0] wbAdr, // byte address
  input wire logic [3:0] wbSel, // byte enables
  input wire logic [31:0] wbDatI, // write data
  output logic [31:0] wbDatO_q, // read data
  output logic wbAck_q // acknowledge
);
  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_SETUP = 3'b001,
    H_TXLO = 3'b010,
    H_TXHI = 3'b011,
    H_WAIT = 3'b100,
    H_RXLO = 3'b101,
    H_RXHI = 3'b110,
    H_GAP = 3'b111
  } hstate_t;

  hstate_t state_q;
  logic [9:0] cnt_q;
  logic [7:0] txByte_q;
  logic endFlag_q, readFlag_q;
  logic [2:0] bitIdx_q;
  logic [4:0] rxIdx_q;
  logic [31:0] keys_q;
  logic csB_q, sclk_q, sdi_q;
  logic sdoSync;
  logic busy;
  logic req;
  logic txWrite;
  logic [9:0] limit;
  logic tick;

  link_sync #(.W(1)) u_sync (
    .mclk(mclk),
    .rst_b(rst_b),
    .async(link.sdoLine),
    .rstVal(1'b1),
    .q(sdoSync)
  );
  assign link.csB = csB_q;
  assign link.sclk = sclk_q;
  assign link.sdi = sdi_q;
  assign busy = (state_q != H_IDLE);
  assign req = wbCyc & wbStb & ~wbAck_q;
  // byte lands at the edge where the master sees ack
  assign txWrite = wbCyc & wbStb & wbAck_q & wbWe &
    (wbAdr == vfd_pkg::WB_TX) & wbSel[1] & wbSel[0] & ~busy;
  always_comb begin
    limit = 10'(HALF_CYCLES - 1);
    if (state_q == H_WAIT) begin
      limit = 10'(TW_CYCLES - 1); // [R18]
    end else if (state_q == H_GAP) begin
      limit = 10'(GAP_CYCLES - 1);
    end
  end
  assign tick = (cnt_q == limit);

  // bus slave, answers one cycle after the request
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wbAck_q <= 1'b0;
      wbDatO_q <= 32'h00000000;
    end else begin
      wbAck_q <= req;
      if (req && !wbWe && wbAdr == vfd_pkg::WB_STAT) begin
        wbDatO_q <= {31'h00000000, busy};
      end else if (req && !wbWe && wbAdr == vfd_pkg::WB_KEYS) begin
        wbDatO_q <= keys_q;
      end else begin
        wbDatO_q <= 32'h00000000;
      end
    end
  end

  // serial sequencer
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= H_IDLE;
      cnt_q <= 10'h000;
      txByte_q <= 8'h00;
      endFlag_q <= 1'b0;
      readFlag_q <= 1'b0;
      bitIdx_q <= 3'h0;
      rxIdx_q <= 5'h00;
      keys_q <= 32'h00000000;
      csB_q <= 1'b1;
      sclk_q <= 1'b1;
      sdi_q <= 1'b1;
    end else begin
      cnt_q <= (tick || state_q == H_IDLE) ? 10'h000 : cnt_q + 10'h001;
      case (state_q)
        H_IDLE: begin
          if (txWrite) begin
            txByte_q <= wbDatI[7:0];
            endFlag_q <= wbDatI[vfd_pkg::TX_END_BIT];
            readFlag_q <= wbDatI[vfd_pkg::TX_READ_BIT];
            bitIdx_q <= 3'h0;
            csB_q <= 1'b0; // [R8]
            state_q <= csB_q ? H_SETUP : H_TXLO;
          end
        end
        H_SETUP: begin
          if (tick) begin
            state_q <= H_TXLO;
          end
        end
        H_TXLO: begin
          sclk_q <= 1'b0;
          sdi_q <= txByte_q[bitIdx_q]; // [R5] [R23]
          if (tick) begin
            state_q <= H_TXHI;
          end
        end
        H_TXHI: begin
          sclk_q <= 1'b1;
          if (tick) begin
            bitIdx_q <= bitIdx_q + 3'h1;
            if (bitIdx_q != 3'h7) begin
              state_q <= H_TXLO;
            end else if (readFlag_q) begin
              rxIdx_q <= 5'h00;
              state_q <= H_WAIT;
            end else if (endFlag_q) begin
              state_q <= H_GAP;
            end else begin
              state_q <= H_IDLE; // [R19] [R20]
            end
          end
        end
        H_WAIT: begin
          if (tick) begin
            state_q <= H_RXLO; // [R18]
          end
        end
        H_RXLO: begin
          sclk_q <= 1'b0;
          if (tick) begin
            state_q <= H_RXHI;
          end
        end
        H_RXHI: begin
          sclk_q <= 1'b1;
          if (tick) begin
            keys_q[rxIdx_q] <= sdoSync; // [R4]
            rxIdx_q <= rxIdx_q + 5'h01;
            state_q <= (rxIdx_q == 5'h1F) ? H_GAP : H_RXLO;
          end
        end
        default: begin
          csB_q <= 1'b1;
          sclk_q <= 1'b1;
          if (tick) begin
            state_q <= H_IDLE;
          end
        end
      endcase
    end
  end
endmodule : vfd_panel_host

// file: tb/vfd_link_checker.sv
// protocol assertions on the panel serial link
`timescale 1ns/1ns
module vfd_link_checker #(
  parameter int HALF = 8,
  parameter int GAP = 4
) (
  input wire logic mclk, // clock
  input wire logic rst_b, // reset, active low
  input wire logic csB, // chip select
  input wire logic sclk, // serial clock
  input wire logic sdi, // data to device
  input wire logic sdoOut, // device read bit
  input wire logic sdoOe, // device drive enable
  input wire logic sdoLine // resolved read line
);
  logic [7:0] lowCnt_q;
  logic [7:0] highCnt_q;
  logic [7:0] csHigh_q;
  logic [2:0] bitCnt_q;

  // phase lengths and bit count within a frame
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      lowCnt_q <= 8'h00;
      highCnt_q <= 8'h00;
      csHigh_q <= 8'hFF;
      bitCnt_q <= 3'h0;
    end else begin
      lowCnt_q <= sclk ? 8'h00 : lowCnt_q + 8'h01;
      if (!sclk) highCnt_q <= 8'h00;
      else if (highCnt_q != 8'hFF) highCnt_q <= highCnt_q + 8'h01;
      if (!csB) csHigh_q <= 8'h00;
      else if (csHigh_q != 8'hFF) csHigh_q <= csHigh_q + 8'h01;
      bitCnt_q <= csB ? 3'h0 : bitCnt_q + 3'($rose(sclk));
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  a_sclk_low: assert property ($rose(sclk) |-> lowCnt_q == 8'(HALF))
    else $error("serial clock low phase has wrong length");
  a_sclk_high: assert property ($fell(sclk) |-> highCnt_q == 8'(HALF) ||
    (bitCnt_q == 3'h0 && highCnt_q > 8'(HALF)))
    else $error("serial clock high phase has wrong length");
  a_whole_bytes: assert property ($rose(csB) |-> bitCnt_q == 3'h0)
    else $error("select rose inside a byte");
  a_select_gap: assert property ($fell(csB) |-> csHigh_q >= 8'(GAP))
    else $error("select high time too short");
  a_cs_rise_high: assert property ($rose(csB) |-> sclk && $past(sclk))
    else $error("select rose while serial clock low");
  a_sdi_steady: assert property (!csB && !$past(csB) && sclk &&
    $past(sclk) |-> $stable(sdi))
    else $error("data changed while serial clock high");
  a_sdo_release: assert property (csB [*6] |-> !sdoOe)
    else $error("read line driven outside a frame");
  a_sdo_drain: assert property (sdoOe |-> !sdoOut && !sdoLine)
    else $error("read line driven high");
  a_sdo_on_low: assert property ($changed(sdoOe) && !csB |-> !sclk)
    else $error("read line changed in high phase");

  c_read: cover property ($rose(sdoOe));
  c_frame: cover property ($rose(csB));
  c_wait: cover property ($fell(sclk) && highCnt_q > 8'(HALF));
endmodule : vfd_link_checker

// file: tb/tb.sv
// self-checking bench for the panel serial host and device ends
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin mismatches++; \
  $display("[ERR] %0t got %0h exp %0h", $time, a, b); end end
module tb;
  localparam int STR = 8;
  localparam int HALF = 8;
  localparam logic [4:0] DIMS [8] = '{5'h01, 5'h02, 5'h04, 5'h0A, 5'h0B,
    5'h0C, 5'h0D, 5'h0E};
  localparam logic [15:0] PATA = 16'h00F1;
  localparam logic [15:0] PATB = 16'hA000;
  logic mclk, rst_b, wbCyc, wbStb, wbWe, wbAck_q, keyA, keyB;
  logic displayOn_q, keyReady_q;
  logic [3:0] wbAdr, wbSel, ledOut_q, modeCode_q, led2;
  logic [31:0] wbDatI, wbDatO_q;
  logic [5:0] dispRdAddr;
  logic [7:0] dispRdData_q, mon;
  logic [15:0] strobes;
  logic [4:0] dimWidth_q;
  int mismatches, checks;
  vfd_link_if link();
  vfd_link_if link2();

  vfd_panel_host #(.HALF_CYCLES(HALF), .TW_CYCLES(4), .GAP_CYCLES(4))
    u_vfd_panel_host (.mclk(mclk), .rst_b(rst_b), .link(link.host),
    .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr),
    .wbSel(wbSel), .wbDatI(wbDatI), .wbDatO_q(wbDatO_q), .wbAck_q(wbAck_q));
  vfd_panel_dev #(.STROBE_CYCLES(STR)) u_vfd_panel_dev (.mclk(mclk),
    .rst_b(rst_b), .link(link.dev), .keyReturnInputA(keyA),
    .keyReturnInputB(keyB), .dispRdAddr(dispRdAddr),
    .dispRdData_q(dispRdData_q), .segmentKeyStrobeOutputs_q(strobes),
    .ledOut_q(ledOut_q), .displayOn_q(displayOn_q),
    .dimWidth_q(dimWidth_q), .modeCode_q(modeCode_q),
    .keyReady_q(keyReady_q));
  // second device end, driven directly for broken frames
  vfd_panel_dev #(.STROBE_CYCLES(STR)) u_vfd_panel_dev2 (.mclk(mclk),
    .rst_b(rst_b), .link(link2.dev), .keyReturnInputA(keyA),
    .keyReturnInputB(keyB), .dispRdAddr(dispRdAddr), .dispRdData_q(),
    .segmentKeyStrobeOutputs_q(), .ledOut_q(led2), .displayOn_q(),
    .dimWidth_q(), .modeCode_q(), .keyReady_q());
  vfd_link_checker #(.HALF(HALF), .GAP(4)) u_vfd_link_checker (
    .mclk(mclk), .rst_b(rst_b), .csB(link.csB), .sclk(link.sclk),
    .sdi(link.sdi), .sdoOut(link.sdoOut), .sdoOe(link.sdoOe),
    .sdoLine(link.sdoLine));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // key matrix: returns follow the active strobe row
  always @(posedge mclk) begin
    keyA <= |(strobes & PATA);
    keyB <= |(strobes & PATB);
  end
  always @(posedge link.sclk) if (!link.csB) mon <= {link.sdi, mon[7:1]};

  task final_report;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report

  task automatic wb(input logic we, input logic [3:0] adr,
    input logic [31:0] d, output logic [31:0] q);
    int n;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbDatI <= d;
    wbSel <= 4'hF;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (wbAck_q !== 1'b1 && n < 100);
    if (wbAck_q !== 1'b1) begin
      mismatches++;
      final_report();
    end
    q = wbDatO_q;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge mclk);
  endtask : wb

  task automatic tx(input logic [7:0] b, input logic endf, input logic rd);
    logic [31:0] q;
    int n;
    wb(1'b1, vfd_pkg::WB_TX, {22'h0, rd, endf, b}, q);
    n = 0;
    do begin
      wb(1'b0, vfd_pkg::WB_STAT, 32'h0, q);
      n++;
    end while (q[0] !== 1'b0 && n < 2000);
    if (q[0] !== 1'b0) begin
      mismatches++;
      final_report();
    end
    if (!rd) `CHK(mon, b)
  endtask : tx

  task automatic frame(input logic [7:0] bs[$]);
    foreach (bs[i]) tx(bs[i], i == bs.size() - 1, 1'b0);
  endtask : frame

  task automatic rdmem(input logic [5:0] a, input logic [7:0] e);
    dispRdAddr <= a;
    repeat (2) @(posedge mclk);
    `CHK(dispRdData_q, e)
  endtask : rdmem

  task automatic t_reset;
    logic [31:0] q;
    `CHK(modeCode_q, 4'h8)
    `CHK(dimWidth_q, 5'h01)
    `CHK(displayOn_q, 1'b0)
    `CHK(ledOut_q, 4'hF)
    `CHK(keyReady_q, 1'b0)
    wb(1'b1, 4'hC, 32'hFFFF_FFFF, q);
    wb(1'b0, 4'hC, 32'h0, q);
    `CHK(q, 32'h0)
  endtask : t_reset

  task automatic t_mem;
    frame('{8'h08});
    frame('{8'h40, 8'h3C});
    rdmem(6'h00, 8'h3C);
    frame('{8'h40});
    frame('{8'hC4, 8'h01, 8'h02, 8'h03});
    rdmem(6'h06, 8'h03);
    frame('{8'h44});
    frame('{8'hC5, 8'hAA, 8'hBB});
    rdmem(6'h05, 8'hBB);
    rdmem(6'h06, 8'h03);
    frame('{8'h40});
    frame('{8'hE2, 8'h11, 8'h22, 8'h33});
    rdmem(6'h23, 8'h22);
    rdmem(6'h00, 8'h3C);
    frame('{8'hE4, 8'h55});
    rdmem(6'h24, 8'h00);
    rdmem(6'h04, 8'h01);
  endtask : t_mem

  task automatic t_led;
    frame('{8'h41, 8'hA5});
    `CHK(ledOut_q, 4'h5)
    frame('{8'h41, 8'h0A});
    `CHK(ledOut_q, 4'hA)
  endtask : t_led

  task automatic t_keys;
    logic [31:0] q, e;
    logic [15:0] seen;
    int bad;
    for (int r = 0; r < 16; r++) begin
      e[2*r] = PATA[r];
      e[2*r+1] = PATB[r];
    end
    frame('{8'h8F});
    seen = 16'h0;
    bad = 0;
    repeat (48 * STR) begin
      @(posedge mclk);
      seen |= strobes;
      if (!$onehot(strobes)) bad++;
    end
    `CHK(seen, 16'hFFFF)
    `CHK(bad, 0)
    `CHK(keyReady_q, 1'b1)
    tx(8'h42, 1'b0, 1'b1);
    wb(1'b0, vfd_pkg::WB_KEYS, 32'h0, q);
    `CHK(q, e)
  endtask : t_keys

  task automatic t_ctrl;
    for (int i = 0; i < 8; i++) begin
      frame('{8'h88 | 8'(i)});
      `CHK(dimWidth_q, DIMS[i])
    end
    `CHK(displayOn_q, 1'b1)
    frame('{8'h08});
    `CHK(displayOn_q, 1'b1)
    frame('{8'h02});
    `CHK(displayOn_q, 1'b0)
    `CHK(modeCode_q, 4'h2)
    `CHK(strobes, 16'h0)
    frame('{8'h0F});
    `CHK(modeCode_q, 4'h8)
  endtask : t_ctrl

  task automatic bb(input logic [7:0] b, input int nb);
    for (int i = 0; i < nb; i++) begin
      link2.sclk <= 1'b0;
      link2.sdi <= b[i];
      repeat (HALF) @(posedge mclk);
      link2.sclk <= 1'b1;
      repeat (HALF) @(posedge mclk);
    end
  endtask : bb

  task automatic t_abort;
    link2.csB <= 1'b0;
    repeat (HALF) @(posedge mclk);
    bb(8'h41, 8);
    bb(8'h03, 8);
    bb(8'h00, 4);
    link2.csB <= 1'b1;
    link2.sdi <= ~link2.sdi;
    repeat (4 * HALF) @(posedge mclk);
    `CHK(led2, 4'h3)
    link2.csB <= 1'b0;
    repeat (HALF) @(posedge mclk);
    bb(8'h41, 8);
    bb(8'h0C, 8);
    `CHK(led2, 4'hC)
    link2.csB <= 1'b1;
  endtask : t_abort

  initial begin
    rst_b = 1'b0;
    wbCyc = 1'b0;
    wbStb = 1'b0;
    wbWe = 1'b0;
    wbAdr = 4'h0;
    wbSel = 4'h0;
    wbDatI = 32'h0;
    dispRdAddr = 6'h00;
    link2.csB = 1'b1;
    link2.sclk = 1'b1;
    link2.sdi = 1'b1;
    mismatches = 0;
    checks = 0;
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    t_reset();
    t_mem();
    t_led();
    t_keys();
    t_ctrl();
    t_abort();
    final_report();
  end
endmodule : tb
